// [rtl/scli_cfg.svh]
// Constants for the serial command line interpreter
`ifndef SCLI_CFG_SVH
`define SCLI_CFG_SVH

// Clock and console format
`define SCLI_CLK_HZ 20000000
`define SCLI_P4_BAUD 1200
`define SCLI_P4_FRAME 8'h81

// Line handling
`define SCLI_LINE_LEN 16
`define SCLI_LEN_W 5
`define SCLI_WORD_LEN 8
`define SCLI_NCMD 8
`define SCLI_HELP_ID 3'h0
`define SCLI_CR 8'h0d
`define SCLI_BS 8'h08
`define SCLI_SPACE 8'h20
`define SCLI_HELP_PARAM 8'h48

// Command table, eight characters per word, space padded
`define SCLI_CMD_TABLE "HELP    SETUP   BUS_MODEDATA    UNIT    SYSPAR  TIME    EVENTS  "

// Message texts; # is replaced by the interface digit
`define SCLI_BANNER_TXT "#### REPORTING UNIT ####\015\012#### COMMAND LINE ####\015\012"
`define SCLI_RESV_TXT "Command reserved, wait a moment and try again\015\012"
`define SCLI_UNK_TXT "?"
`define SCLI_PROMPT_TXT "-"
`define SCLI_HELP_TXT "HELP SETUP BUS_MODE DATA UNIT SYSPAR TIME EVENTS\015\012"

`endif

// [rtl/scli_pkg.sv]
// Types of the serial command line interpreter
package scli_pkg;
`include "scli_cfg.svh"

  typedef enum logic [5:0] {
    MSG_IDLE   = 6'h01,
    MSG_BANNER = 6'h02,
    MSG_RESV   = 6'h04,
    MSG_UNK    = 6'h08,
    MSG_HELP   = 6'h10,
    MSG_PROMPT = 6'h20
  } scli_msg_t;

  typedef logic [`SCLI_LINE_LEN-1:0][7:0] scli_line_t;

  typedef struct packed {
    scli_line_t [3:0] line;
    logic [3:0][`SCLI_LEN_W-1:0] len;
    logic [3:0] ban_p;
    logic [3:0] res_p;
    logic [3:0] unk_p;
    logic [3:0] hlp_p;
    logic [3:0] pr_p;
    logic [3:0] term_q;
    logic [`SCLI_NCMD-1:0] resv;
    logic [`SCLI_NCMD-1:0][1:0] own;
    scli_msg_t msg;
    logic [1:0] mport;
    logic [6:0] midx;
    logic sw_m;
    logic sw_s;
    logic rx_ready;
    logic tx_v;
    logic [1:0] tx_port;
    logic [7:0] tx_data;
    logic cmd_valid;
    logic [2:0] cmd_id;
    logic [1:0] cmd_port;
    logic cmd_help;
    scli_line_t cmd_param;
    logic [`SCLI_LEN_W-1:0] cmd_plen;
    logic p4_force;
    logic [15:0] p4_bit;
    logic [7:0] p4_frame;
  } scli_st_t;
endpackage

// [rtl/scli_strm_if.sv]
// Valid/ready byte stream between interpreter and its FIFO
`timescale 1ns/1ps
interface scli_strm_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [rtl/scli_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module scli_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Streams
  scli_strm_if.snk fill,
  scli_strm_if.src drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } scli_fifo_st_t;

  scli_fifo_st_t q;
  scli_fifo_st_t d;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign fill.ready = q.cnt != (AW+1)'(DEPTH);
  assign drain.valid = q.cnt != '0;
  assign drain.data = q.mem[q.rd];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // Next state: write, read and count
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = fill.data;
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
    end
    if (pop) begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
    end
    if (push && !pop) begin
      d.cnt = q.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      d.cnt = q.cnt - (AW+1)'(1);
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // scli_fifo

// [rtl/scli_top.sv]
// Serial command line interpreter: line editing, dispatch, reservations, messages
`timescale 1ns/1ps
`include "scli_cfg.svh"
module scli_top import scli_pkg::*; #(
  parameter int P4_BIT_CYC = `SCLI_CLK_HZ / `SCLI_P4_BAUD,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Front panel console switch pin
  input wire logic I_CONSOLE_SW,
  // Terminal mode of each interface
  input wire logic [3:0] I_TERM_MODE,
  // Received bytes from the serial interfaces
  input wire logic I_RX_VALID,
  input wire logic [1:0] I_RX_PORT,
  input wire logic [7:0] I_RX_DATA,
  output logic O_RX_READY,
  // Bytes to send to the serial interfaces
  output logic O_TX_VALID,
  output logic [1:0] O_TX_PORT,
  output logic [7:0] O_TX_DATA,
  input wire logic I_TX_READY,
  // Command dispatch to the execution side
  output logic O_CMD_VALID,
  output logic [2:0] O_CMD_ID,
  output logic [1:0] O_CMD_PORT,
  output logic O_CMD_HELP,
  output logic [`SCLI_LINE_LEN*8-1:0] O_CMD_PARAM,
  output logic [`SCLI_LEN_W-1:0] O_CMD_PLEN,
  // Command completion
  input wire logic I_DONE_VALID,
  input wire logic [2:0] I_DONE_ID,
  // Forced format of interface 4
  output logic O_P4_FORCE,
  output logic [15:0] O_P4_BIT_CYC,
  output logic [7:0] O_P4_FRAME
);
  localparam int LW = `SCLI_LINE_LEN;
  localparam int NC = `SCLI_NCMD;
  localparam TBL = `SCLI_CMD_TABLE;
  localparam BAN = `SCLI_BANNER_TXT;
  localparam RES = `SCLI_RESV_TXT;
  localparam UNK = `SCLI_UNK_TXT;
  localparam PRM = `SCLI_PROMPT_TXT;
  localparam HLP = `SCLI_HELP_TXT;
  localparam int BAN_N = $bits(BAN) / 8;
  localparam int RES_N = $bits(RES) / 8;
  localparam int HLP_N = $bits(HLP) / 8;

  scli_st_t q;
  scli_st_t d;
  logic [8:0] cur_ch;

  scli_strm_if #(.W(10)) tin ();
  scli_strm_if #(.W(10)) tout ();

  // Character of a message at an index, with a last-character flag on top
  function automatic logic [8:0] msg_char(scli_msg_t m, logic [6:0] i, logic [1:0] p);
    logic [7:0] c;
    logic last;
    c = 8'h00;
    last = 1'b1;
    unique case (m)
      MSG_BANNER: begin
        c = BAN[8*(BAN_N-1-int'(i)) +: 8];
        // Frame characters carry the interface digit
        if (c == 8'h23) begin
          c = 8'h31 + {6'h00, p};
        end
        last = int'(i) == BAN_N - 1;
      end
      MSG_RESV: begin
        c = RES[8*(RES_N-1-int'(i)) +: 8];
        last = int'(i) == RES_N - 1;
      end
      MSG_HELP: begin
        c = HLP[8*(HLP_N-1-int'(i)) +: 8];
        last = int'(i) == HLP_N - 1;
      end
      MSG_UNK: c = UNK[7:0];
      MSG_PROMPT: c = PRM[7:0];
      MSG_IDLE: c = 8'h00;
      default: c = 8'h00;
    endcase
    return {last, c};
  endfunction

  // Emitter feeds the FIFO directly from state
  assign cur_ch = msg_char(q.msg, q.midx, q.mport);
  assign tin.valid = q.msg != MSG_IDLE;
  assign tin.data = {q.mport, cur_ch[7:0]};
  // Output stage refills whenever it is empty or being taken
  assign tout.ready = !q.tx_v || I_TX_READY;

  scli_fifo #(
    .W(10),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_MCLK),
    .i_reset(I_RESET),
    .fill(tin.snk),
    .drain(tout.src)
  );

  // Next state of the whole interpreter
  always_comb begin
    logic [3:0] term;
    logic found;
    logic [7:0] b;
    scli_line_t ln;
    logic [`SCLI_LEN_W-1:0] n;
    logic [`SCLI_LEN_W-1:0] sp;
    logic [`SCLI_LEN_W-1:0] plen;
    logic [7:0][7:0] wd;
    scli_line_t prm;
    logic hit;
    logic [2:0] id;
    int k;
    term = 4'h0;
    found = 1'b0;
    b = 8'h00;
    ln = '0;
    n = '0;
    sp = '0;
    plen = '0;
    wd = '0;
    prm = '0;
    hit = 1'b0;
    id = 3'h0;
    k = 0;
    d = q;
    d.cmd_valid = 1'b0;
    d.rx_ready = 1'b1;

    // Console switch pin, two flip-flops before use
    d.sw_m = I_CONSOLE_SW;
    d.sw_s = q.sw_m;
    d.p4_force = q.sw_s;
    d.p4_bit = q.sw_s ? P4_BIT_CYC[15:0] : 16'h0000;
    d.p4_frame = q.sw_s ? `SCLI_P4_FRAME : 8'h00;

    term = I_TERM_MODE | {q.sw_s, 3'b000};
    d.term_q = term;

    // Pick the next message; lowest interface first, banner before the rest
    if (q.msg == MSG_IDLE) begin
      for (int p = 0; p < 4; p++) begin
        if (!found && (q.ban_p[p] || q.res_p[p] || q.unk_p[p] || q.hlp_p[p] || q.pr_p[p])) begin
          found = 1'b1;
          d.mport = 2'(p);
          d.midx = 7'h00;
          if (q.ban_p[p]) begin
            d.msg = MSG_BANNER;
            d.ban_p[p] = 1'b0;
          end else if (q.res_p[p]) begin
            d.msg = MSG_RESV;
            d.res_p[p] = 1'b0;
          end else if (q.unk_p[p]) begin
            d.msg = MSG_UNK;
            d.unk_p[p] = 1'b0;
          end else if (q.hlp_p[p]) begin
            d.msg = MSG_HELP;
            d.hlp_p[p] = 1'b0;
          end else begin
            d.msg = MSG_PROMPT;
            d.pr_p[p] = 1'b0;
          end
        end
      end
    end else if (tin.ready) begin
      if (cur_ch[8]) begin
        d.msg = MSG_IDLE;
        if (q.msg != MSG_PROMPT && q.msg != MSG_BANNER) begin
          d.pr_p[q.mport] = 1'b1;
        end
      end else begin
        d.midx = q.midx + 7'h01;
      end
    end

    // banner on entry to terminal mode
    // Reset clears term_q, so ports already in terminal mode banner after reset
    d.ban_p = d.ban_p | (term & ~q.term_q);

    if (I_DONE_VALID && q.resv[I_DONE_ID]) begin
      d.resv[I_DONE_ID] = 1'b0;
      d.pr_p[q.own[I_DONE_ID]] = 1'b1;
    end

    // received bytes edit the line or submit it on carriage return, nothing loops back
    if (I_RX_VALID && q.rx_ready && term[I_RX_PORT]) begin
      b = I_RX_DATA;
      ln = q.line[I_RX_PORT];
      n = q.len[I_RX_PORT];
      if (b == `SCLI_CR) begin
        d.len[I_RX_PORT] = '0;
        // first space splits word from parameters
        sp = n;
        for (int i = LW - 1; i >= 0; i--) begin
          if (i < int'(n) && ln[i] == `SCLI_SPACE) begin
            sp = `SCLI_LEN_W'(i);
          end
        end
        for (int i = 0; i < 8; i++) begin
          wd[7-i] = (i < int'(sp)) ? ln[i] : `SCLI_SPACE;
        end
        plen = (sp < n) ? n - sp - `SCLI_LEN_W'(1) : '0;
        for (int j = 0; j < LW; j++) begin
          k = int'(sp) + 1 + j;
          prm[j] = (j < int'(plen) && k < LW) ? ln[k] : 8'h00;
        end
        // Known word lookup; longer words cannot match
        for (int c = 0; c < NC; c++) begin
          if (wd == TBL[64*(NC-1-c) +: 64] && int'(sp) <= `SCLI_WORD_LEN) begin
            hit = 1'b1;
            id = 3'(c);
          end
        end
        if (n == '0) begin
          d.pr_p[I_RX_PORT] = 1'b1;
        end else if (!hit) begin
          d.unk_p[I_RX_PORT] = 1'b1;
        end else if (id == `SCLI_HELP_ID) begin
          d.hlp_p[I_RX_PORT] = 1'b1;
        end else if (d.resv[id]) begin
          d.res_p[I_RX_PORT] = 1'b1;
        end else begin
          d.resv[id] = 1'b1;
          d.own[id] = I_RX_PORT;
          d.cmd_valid = 1'b1;
          d.cmd_id = id;
          d.cmd_port = I_RX_PORT;
          d.cmd_param = prm;
          d.cmd_plen = plen;
          d.cmd_help = plen == `SCLI_LEN_W'(1) && prm[0] == `SCLI_HELP_PARAM;
        end
      end else if (b == `SCLI_BS) begin
        if (n != '0) begin
          d.len[I_RX_PORT] = n - `SCLI_LEN_W'(1);
        end
      end else if (int'(n) < LW) begin
        // fold lower case; national codes above z stay as they are
        if (b >= 8'h61 && b <= 8'h7a) begin
          b = b - 8'h20;
        end
        d.line[I_RX_PORT][n[`SCLI_LEN_W-2:0]] = b;
        d.len[I_RX_PORT] = n + `SCLI_LEN_W'(1);
      end
    end

    // Output register stage; the emitter stalls when the FIFO fills
    if (tout.ready) begin
      d.tx_v = tout.valid;
      d.tx_port = tout.data[9:8];
      d.tx_data = tout.data[7:0];
    end
  end

  // State register; idle message code is the only non-zero reset bit
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      q <= '0;
      q.msg <= MSG_IDLE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign O_RX_READY = q.rx_ready;
  assign O_TX_VALID = q.tx_v;
  assign O_TX_PORT = q.tx_port;
  assign O_TX_DATA = q.tx_data;
  assign O_CMD_VALID = q.cmd_valid;
  assign O_CMD_ID = q.cmd_id;
  assign O_CMD_PORT = q.cmd_port;
  assign O_CMD_HELP = q.cmd_help;
  assign O_CMD_PARAM = q.cmd_param;
  assign O_CMD_PLEN = q.cmd_plen;
  assign O_P4_FORCE = q.p4_force;
  assign O_P4_BIT_CYC = q.p4_bit;
  assign O_P4_FRAME = q.p4_frame;
endmodule // scli_top

// [testbench/scli_top_assertions.sv]
// Checker of the interpreter's top ports
`timescale 1ns/1ps
module scli_chk #(
  parameter int P4_BIT_CYC = 16666
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Inputs watched
  input wire logic I_CONSOLE_SW,
  input wire logic I_TX_READY,
  input wire logic I_DONE_VALID,
  input wire logic [2:0] I_DONE_ID,
  // Outputs watched
  input wire logic O_TX_VALID,
  input wire logic [1:0] O_TX_PORT,
  input wire logic [7:0] O_TX_DATA,
  input wire logic O_CMD_VALID,
  input wire logic [2:0] O_CMD_ID,
  input wire logic O_CMD_HELP,
  input wire logic [127:0] O_CMD_PARAM,
  input wire logic [4:0] O_CMD_PLEN,
  input wire logic O_P4_FORCE,
  input wire logic [15:0] O_P4_BIT_CYC,
  input wire logic [7:0] O_P4_FRAME
);
  logic [1:0] up_q;
  logic [7:0] busy_q;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  // Edges since reset, and commands in flight; set wins over clear
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      up_q <= 2'h0;
      busy_q <= 8'h00;
    end else begin
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
      busy_q <= (busy_q & ~(I_DONE_VALID ? 8'h01 << I_DONE_ID : 8'h00))
        | (O_CMD_VALID ? 8'h01 << O_CMD_ID : 8'h00);
    end
  end
  a_tx_holds: assert property (
    O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable({O_TX_PORT, O_TX_DATA}))
    else $error("tx byte changed before taken");
  a_cmd_pulse: assert property (
    O_CMD_VALID |=> !O_CMD_VALID || !$stable(O_CMD_ID))
    else $error("dispatch pulse repeated");
  a_help_inside: assert property (O_CMD_VALID |-> O_CMD_ID != 3'h0)
    else $error("help command dispatched outside");
  a_help_flag: assert property (
    O_CMD_VALID && O_CMD_HELP |-> O_CMD_PLEN == 5'h01 && O_CMD_PARAM[7:0] == 8'h48)
    else $error("help flag without single H");
  a_upper_case: assert property (
    O_CMD_VALID |-> !(O_CMD_PARAM[7:0] inside {[8'h61:8'h7a]}))
    else $error("parameter not folded to upper case");
  a_one_owner: assert property (O_CMD_VALID |-> !busy_q[O_CMD_ID])
    else $error("command dispatched while still running");
  a_p4_format: assert property (
    O_P4_BIT_CYC == (O_P4_FORCE ? 16'(P4_BIT_CYC) : 16'h0000)
    && O_P4_FRAME == (O_P4_FORCE ? 8'h81 : 8'h00))
    else $error("console format wrong");
  a_p4_follow: assert property (
    up_q == 2'h3 |-> O_P4_FORCE == $past(I_CONSOLE_SW, 3))
    else $error("console switch not followed in three edges");
endmodule // scli_chk

// [testbench/scli_term.sv]
// Terminal model on the interpreter's byte streams
`timescale 1ns/1ps
module scli_term (
  // Clock, reset and pace
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_slow,
  // Bytes typed to the block
  output logic o_rx_valid,
  output logic [1:0] o_rx_port,
  output logic [7:0] o_rx_data,
  // Bytes shown from the block
  input wire logic i_tx_valid,
  input wire logic [1:0] i_tx_port,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  logic [7:0] got[4][$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_port = 2'h0;
    o_rx_data = 8'h00;
  end
  // national codes 5B-5D and 7B-7D travel as plain bytes both ways
  // typed line, backspace as 08, carriage return appended
  task automatic send(input logic [1:0] p, input string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_port <= p;
      o_rx_data <= (i == s.len()) ? 8'h0d : s[i];
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~o_rx_data;
  endtask
  // screen keeps what arrives; slow pace stalls the block's buffer
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
      if (i_tx_valid && o_tx_ready) got[i_tx_port].push_back(i_tx_data);
    end
  end
endmodule // scli_term

// [testbench/tb_serial_command_line_interpreter.sv]
// Self-checking bench of the serial command line interpreter
`timescale 1ns/1ps
`include "scli_cfg.svh"
module tb_serial_command_line_interpreter;
  localparam int P4C = `SCLI_CLK_HZ / `SCLI_P4_BAUD;
  logic mclk = 1'b0, reset = 1'b1, sw = 1'b0, slow = 1'b0;
  logic done_valid = 1'b0, rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid, cmd_help, p4_force;
  logic [3:0] term_mode = 4'h1;
  logic [2:0] done_id = 3'h0, cmd_id;
  logic [1:0] rx_port, tx_port, cmd_port;
  logic [7:0] rx_data, tx_data, p4_frame;
  logic [127:0] cmd_param;
  logic [4:0] cmd_plen;
  logic [15:0] p4_bit_cyc;
  int n_mismatch = 0, total_checks = 0, n_cmd = 0, cyc = 0;
  scli_top #(.P4_BIT_CYC(P4C), .FIFO_DEPTH(4)) i_dut (.I_MCLK(mclk), .I_RESET(reset),
    .I_CONSOLE_SW(sw), .I_TERM_MODE(term_mode), .I_RX_VALID(rx_valid), .I_RX_PORT(rx_port),
    .I_RX_DATA(rx_data), .O_RX_READY(rx_ready), .O_TX_VALID(tx_valid), .O_TX_PORT(tx_port),
    .O_TX_DATA(tx_data), .I_TX_READY(tx_ready), .O_CMD_VALID(cmd_valid), .O_CMD_ID(cmd_id),
    .O_CMD_PORT(cmd_port), .O_CMD_HELP(cmd_help), .O_CMD_PARAM(cmd_param),
    .O_CMD_PLEN(cmd_plen), .I_DONE_VALID(done_valid), .I_DONE_ID(done_id),
    .O_P4_FORCE(p4_force), .O_P4_BIT_CYC(p4_bit_cyc), .O_P4_FRAME(p4_frame));
  scli_term i_term (.i_clk(mclk), .i_reset(reset), .i_slow(slow), .o_rx_valid(rx_valid),
    .o_rx_port(rx_port), .o_rx_data(rx_data), .i_tx_valid(tx_valid), .i_tx_port(tx_port),
    .i_tx_data(tx_data), .o_tx_ready(tx_ready));
  always #25 mclk = ~mclk;
  // Dispatch count and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic bad(input string m);
    n_mismatch++;
    $display("ERROR %0t %s", $time, m);
  endtask
  // Whole message on one port, with time for stray extra bytes to show
  task automatic chk_txt(input int p, input string e);
    int w = 0, k = 0;
    while (i_term.got[p].size() < e.len() && w < 4000) begin
      @(posedge mclk);
      w++;
    end
    repeat (20) @(posedge mclk);
    total_checks++;
    foreach (i_term.got[p][i]) k += int'(i_term.got[p][i] !== e[i]);
    if (i_term.got[p].size() != e.len() || k != 0) bad("message text");
    i_term.got[p].delete();
  endtask
  task automatic chk_cmd(input int n, input logic [2:0] id, input logic [1:0] p,
      input logic h, input logic [4:0] len, input logic [127:0] prm);
    repeat (4) @(posedge mclk);
    total_checks++;
    if (n_cmd != n || cmd_id !== id || cmd_port !== p || cmd_help !== h) bad("dispatch");
    else if (cmd_plen !== len || cmd_param !== prm) bad("dispatch parameters");
  endtask
  // Forced console format against the switch level
  task automatic chk_p4(input logic f);
    total_checks++;
    if (p4_force !== f || p4_bit_cyc !== (f ? 16'(P4C) : 16'h0000)
        || p4_frame !== (f ? 8'h81 : 8'h00)) bad("console");
  endtask
  // Receive side must stay open after reset
  task automatic chk_ready();
    total_checks++;
    if (rx_ready !== 1'b1) bad("receive ready");
  endtask
  task automatic done(input logic [2:0] id);
    @(posedge mclk);
    done_valid <= 1'b1;
    done_id <= id;
    @(posedge mclk);
    done_valid <= 1'b0;
  endtask
  function automatic string ban(input byte d);
    string s = `SCLI_BANNER_TXT;
    foreach (s[i]) if (s[i] == 8'h23) s[i] = d;
    return s;
  endfunction
  task automatic t_power();
    chk_txt(0, ban(8'h31));
    chk_ready();
    chk_p4(1'b0);
    @(posedge mclk);
    sw <= 1'b1;
    repeat (5) @(posedge mclk);
    chk_p4(1'b1);
    chk_txt(3, ban(8'h34));
    i_term.send(2'h3, "");
    chk_txt(3, "-");
    $display("power done");
  endtask
  task automatic t_lines();
    i_term.send(2'h3, "xyz");
    chk_txt(3, "?-");
    slow <= 1'b1;
    i_term.send(2'h3, "help");
    chk_txt(3, {`SCLI_HELP_TXT, "-"});
    slow <= 1'b0;
    i_term.send(2'h3, "sEtuq\010p ab");
    chk_cmd(1, 3'h1, 2'h3, 1'b0, 5'h02, 128'h4241);
    $display("lines done");
  endtask
  task automatic t_reserve();
    i_term.send(2'h0, "setup h");
    chk_txt(0, {`SCLI_RESV_TXT, "-"});
    done(3'h1);
    chk_txt(3, "-");
    i_term.send(2'h0, "SETUP h");
    chk_cmd(2, 3'h1, 2'h0, 1'b1, 5'h01, 128'h48);
    done(3'h1);
    chk_txt(0, "-");
    i_term.send(2'h0, "data x{");
    chk_cmd(3, 3'h3, 2'h0, 1'b0, 5'h02, 128'h7b58);
    done(3'h3);
    chk_txt(0, "-");
    $display("reserve done");
  endtask
  task automatic t_mode();
    i_term.send(2'h1, "help");
    chk_txt(1, "");
    term_mode <= 4'h3;
    chk_txt(1, ban(8'h32));
    i_term.send(2'h1, "");
    chk_txt(1, "-");
    sw <= 1'b0;
    repeat (5) @(posedge mclk);
    chk_p4(1'b0);
    $display("mode done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_power();
    t_lines();
    t_reserve();
    t_mode();
    close_out();
  end
endmodule // tb_serial_command_line_interpreter
bind scli_top scli_chk #(.P4_BIT_CYC(P4_BIT_CYC)) i_chk (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
  .I_CONSOLE_SW(I_CONSOLE_SW), .I_TX_READY(I_TX_READY), .I_DONE_VALID(I_DONE_VALID),
  .I_DONE_ID(I_DONE_ID), .O_TX_VALID(O_TX_VALID), .O_TX_PORT(O_TX_PORT),
  .O_TX_DATA(O_TX_DATA), .O_CMD_VALID(O_CMD_VALID), .O_CMD_ID(O_CMD_ID),
  .O_CMD_HELP(O_CMD_HELP), .O_CMD_PARAM(O_CMD_PARAM), .O_CMD_PLEN(O_CMD_PLEN),
  .O_P4_FORCE(O_P4_FORCE), .O_P4_BIT_CYC(O_P4_BIT_CYC), .O_P4_FRAME(O_P4_FRAME));
